// [cbtsc_btl.sv]
`default_nettype none
module cbtsc_btl
  import cbtsc_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic enable, // Runs the prescaler and segments.
  input wire logic rxBit, // Bus level, 0 is dominant.
  input wire cbtsc_timing_t cfg, // Timing configuration.
  output var cbtsc_bit_t bitOut // Sample and bit end strobes.
);

  logic [5:0] presQ;
  logic tq;
  logic rxPrevQ;
  logic usedQ;
  logic edgeSeen;
  cbtsc_seg_t segQ;
  logic [4:0] cntQ;
  logic [4:0] len1Q;
  logic [3:0] len2Q;
  logic [4:0] sjw;
  logic [4:0] len1;
  logic [3:0] len2;
  logic [4:0] err1;
  logic [4:0] ext1;
  logic [4:0] err2;
  logic [4:0] len1Eff;
  logic [3:0] len2Eff;
  logic short2;
  logic leave1;
  logic leave2;
  logic sampleQ;
  logic endQ;
  logic valueQ;

  assign tq = enable && (presQ == cfg.prescale); // R24
  assign sjw = {3'h0, cfg.jump} + 5'h01; // R24
  assign len1 = {1'b0, cfg.seg1} + 5'h01; // R25
  assign len2 = {1'b0, cfg.seg2} + 4'h1; // R25
  // Only a recessive-to-dominant edge resynchronises, and once per bit.
  assign edgeSeen = tq && rxPrevQ && !rxBit && !usedQ;
  assign err1 = cntQ + 5'h01;
  assign ext1 = (err1 < sjw) ? err1 : sjw; // R4
  assign err2 = {1'b0, len2Q} - cntQ;
  assign short2 = edgeSeen && (segQ == SEG_TWO) && (err2 <= sjw); // R23
  assign len1Eff = (edgeSeen && segQ == SEG_ONE) ? len1Q + ext1 : len1Q; // R2
  assign len2Eff = (edgeSeen && segQ == SEG_TWO) ? len2Q - sjw[3:0] : len2Q; // R3
  assign leave1 = tq && (segQ == SEG_ONE) && (cntQ + 5'h01 >= len1Eff);
  assign leave2 = tq && (segQ == SEG_TWO) && (short2 || cntQ + 5'h01 >= {1'b0, len2Eff});

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      presQ <= 6'h00;
    else if (!enable || tq)
      presQ <= 6'h00;
    else
      presQ <= presQ + 6'h01;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rxPrevQ <= 1'b1;
    else if (!enable)
      rxPrevQ <= 1'b1;
    else if (tq)
      rxPrevQ <= rxBit;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      segQ <= SEG_SYNC;
      cntQ <= 5'h00;
      len1Q <= 5'h01;
      len2Q <= 4'h1;
      usedQ <= 1'b0;
    end
    else if (!enable)
    begin
      segQ <= SEG_SYNC;
      cntQ <= 5'h00;
      usedQ <= 1'b0;
    end
    else if (tq)
    begin
      case (segQ)
        SEG_SYNC:
        begin
          segQ <= SEG_ONE; // R1
          cntQ <= 5'h00;
          len1Q <= len1;
          len2Q <= len2;
          usedQ <= 1'b0;
        end
        SEG_ONE:
        begin
          len1Q <= len1Eff;
          if (edgeSeen)
            usedQ <= 1'b1;
          if (leave1)
          begin
            segQ <= SEG_TWO;
            cntQ <= 5'h00;
          end
          else
            cntQ <= cntQ + 5'h01;
        end
        SEG_TWO:
        begin
          if (edgeSeen)
            usedQ <= 1'b1;
          if (short2)
          begin
            // The early edge stands in for the sync segment of the next bit.
            segQ <= SEG_ONE; // R23
            cntQ <= 5'h00;
            len1Q <= len1;
            len2Q <= len2;
          end
          else if (leave2)
          begin
            segQ <= SEG_SYNC;
            cntQ <= 5'h00;
          end
          else
          begin
            len2Q <= len2Eff;
            cntQ <= cntQ + 5'h01;
          end
        end
        default:
          segQ <= SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sampleQ <= 1'b0;
      endQ <= 1'b0;
      valueQ <= 1'b1;
    end
    else
    begin
      sampleQ <= leave1; // R2
      endQ <= leave2; // R3
      if (leave1)
        valueQ <= rxBit;
    end
  end

  always_comb
  begin
    bitOut = '{sampleTick: sampleQ, bitEnd: endQ, bitValue: valueQ};
  end

  chk_sync_one_tq: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tq && segQ == SEG_SYNC) |=> (segQ == SEG_ONE || !enable)) // R1
    else $error("sync segment lasted more than one quantum");

  chk_seg1_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tq && segQ == SEG_ONE) |-> (len1Eff <= len1 + sjw)) // R4
    else $error("first segment grew beyond the jump width");

endmodule
`default_nettype wire

// [cbtsc_node.sv]
`default_nettype none
module cbtsc_node (
  input wire logic nodeTx, // Level the block drives, 0 is dominant.
  input wire logic holdDom, // Far node drives a dominant level.
  output logic busLine // Shared bus level seen by every node.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The line is pulled recessive, so a released bus reads 1 and any dominant driver wins.
  assign busLine = nodeTx & ~holdDom;
endmodule
`default_nettype wire

// [cbtsc_pkg.sv]
`default_nettype none
package cbtsc_pkg;

  // Register byte addresses on the bus.
  localparam logic [7:0] ADR_FLAGS = 8'h00;
  localparam logic [7:0] ADR_ENABLES = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_PRESC = 8'h0c;
  localparam logic [7:0] ADR_TIMING = 8'h10;
  localparam logic [7:0] ADR_PAGE = 8'h14;
  // The paged window spans 0x40 to 0x7c, sixteen words.
  localparam logic [1:0] WIN_TAG = 2'h1;

  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PRESC = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h23;
  localparam logic [2:0] RST_PAGE = 3'h0;

  // Bit positions in the flag register.
  localparam int FL_PEND = 0;
  localparam int FL_TXERR = 1;
  localparam int FL_OVR = 2;
  localparam int FL_STAT = 3;
  localparam int FL_TXDONE = 4;
  localparam int FL_RX1 = 5;
  localparam int FL_RX3 = 7;
  // Bit positions in the enable register.
  localparam int EN_EARLY = 0;
  localparam int EN_TXERR = 1;
  localparam int EN_OVR = 2;
  localparam int EN_STAT = 3;
  localparam int EN_TX = 4;
  localparam int EN_RX = 5;
  localparam int EN_RXERR = 6;
  // Bit positions in the control/status register.
  localparam int CT_RUN = 0;
  localparam int CT_WAKE = 1;
  localparam int CT_FAST = 2;
  localparam int CT_NORETRY = 3;
  localparam int CT_SELFRX = 4;
  localparam int CT_PASSIVE = 5;
  localparam int CT_BUSOFF = 6;

  localparam logic [3:0] RECESSIVE_RUN = 4'hb;
  localparam logic [7:0] RESYNC_SEQS = 8'h80;
  localparam logic [8:0] TEC_PASSIVE = 9'h07f;
  localparam logic [7:0] REC_PASSIVE = 8'h7f;
  localparam logic [8:0] TEC_BUSOFF = 9'h0ff;

  typedef struct packed {
    logic [1:0] jump;
    logic [5:0] prescale;
  } cbtsc_presc_t;

  typedef struct packed {
    logic spare;
    logic [2:0] seg2;
    logic [3:0] seg1;
  } cbtsc_btr_t;

  typedef struct packed {
    logic [5:0] prescale;
    logic [1:0] jump;
    logic [3:0] seg1;
    logic [2:0] seg2;
  } cbtsc_timing_t;

  typedef struct packed {
    logic [2:0] rxOk;
    logic txDone;
    logic arbWon;
    logic txErr;
    logic rxErr;
    logic overrun;
    logic [2:0] rdyCleared;
    logic xferBusy;
    logic txBit;
  } cbtsc_core_t;

  typedef struct packed {
    logic sampleTick;
    logic bitEnd;
    logic bitValue;
  } cbtsc_bit_t;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_WAKEUP = 2'b01,
    MODE_RESYNC = 2'b10,
    MODE_ACTIVE = 2'b11
  } cbtsc_mode_t;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_ONE = 2'b01,
    SEG_TWO = 2'b10
  } cbtsc_seg_t;

endpackage
`default_nettype wire

// [cbtsc_top.sv]
// Notes on behaviour
// (R1) Each bit opens with a one-quantum sync segment where an edge is expected.
// (R2) First segment is 1..16 quanta, ends at sample point, lengthens for late edges.
// (R3) Second segment is 1..8 quanta, ends at transmit point, shortens for early edges.
// (R4) Lengthening or shortening never exceeds the jump width of 1..4 quanta.
// (R5) Software keeps sync plus both segments at five quanta or more.
// (R6) Timing configuration is written only in standby; other writes are dropped.
// (R7) Six general registers plus a paged window of sixteen, page chosen by register.
// (R8) Receive flag per buffer sets on good message, clears by software or ready clear.
// (R9) Transmit-done sets on completion, or on arbitration won when early notify is on.
// (R10) Status flag sets on dominant in standby, passive or bus-off entry, receive errors.
// (R11) Overrun flag sets when an accepted message finds no free buffer.
// (R12) Transmit error flag sets on an error sending the top queued message.
// (R13) Error pending reads 1 while status, overrun or transmit error flag is set.
// (R14) Writing 0 to a flag bit clears it; writing 1 leaves it.
// (R15) With the receive-error option set, every receive error sets the status flag.
// (R16) Interrupt request is raised only for flags whose enable bit is set.
// (R17) Bus-off bit sets when transmit errors exceed 255, clears on rejoining the bus.
// (R18) Error passive bit sets while passive, clears when active or bus-off.
// (R19) Self receive enable lets own frames be received; otherwise they are dropped.
// (R20) No-retry bit stops retransmission of failed frames.
// (R21) Leaving standby waits 11 recessive bits if fast, else 128 such sequences; the fast bit is ignored while bus-off is set.
// (R22) Wake pulse option drives one dominant bit when leaving standby.
// (R23) Edges outside sync adjust the bit by the phase error, capped at jump width.
// (R24) Quantum is clock period times prescaler plus one; jump width is field plus one.
// (R25) Segment lengths are their timing register fields plus one quantum.
// (R26) After run is cleared, run reads 1 until standby is really entered.
//
// The Wishbone register port and the address map were chosen for this implementation.
`default_nettype none
module cbtsc_top
  import cbtsc_pkg::*;
(
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Write enable.
  input wire logic [7:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte lane selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Acknowledge.
  input wire logic canRx, // Bus level, 0 is dominant.
  output logic canTx, // Driven bus level, 0 is dominant.
  input wire cbtsc_core_t core, // Event strobes from the protocol core.
  input wire logic [8:0] tecCount, // Transmit error counter.
  input wire logic [7:0] recCount, // Receive error counter.
  input wire logic [7:0] pageRdata, // Read data from the paged window.
  output var cbtsc_bit_t bitInfo, // Bit timing strobes to the core.
  output logic coreRun, // Core may transmit and receive.
  output logic selfReceive, // Keep own frames in reception.
  output logic noRetry, // Do not retransmit failed frames.
  output logic earlyTx, // Early transmit notification.
  output logic [2:0] pageSel, // Selected page.
  output logic pageWrite, // Write strobe into the paged window.
  output logic [3:0] pageIndex, // Word index inside the window.
  output logic [7:0] pageWdata, // Write data for the window.
  output logic irqReq // Interrupt request, active high.
);

  cbtsc_mode_t modeQ;
  logic ackQ;
  logic [7:0] rdQ;
  logic [7:1] flagQ;
  logic [6:0] enQ;
  logic [4:0] ctrlQ;
  cbtsc_presc_t prescQ;
  cbtsc_btr_t timingQ;
  logic [2:0] pageQ;
  logic busOffQ;
  logic passPrevQ;
  logic boffPrevQ;
  logic [3:0] recRunQ;
  logic [6:0] seqQ;
  logic canTxQ;
  logic acc;
  logic wrEn;
  logic inWin;
  logic runRead;
  logic cfgOpen;
  logic errPassive;
  logic fastOk;
  logic resyncDone;
  logic statSet;
  logic txSet;
  logic pending;
  logic [7:0] flagsRd;
  logic [7:0] ctrlRd;
  logic [7:0] rdMux;
  logic [7:1] flagSet;
  logic [7:1] flagClr;
  cbtsc_timing_t cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave. Ack follows one cycle after the request; writes land on the
  // acknowledging edge, so a master that holds its request sees one effect.

  assign acc = wb_cyc_i && wb_stb_i;
  assign wrEn = acc && wb_we_i && ackQ && wb_sel_i[0];
  assign inWin = (wb_adr_i[7:6] == WIN_TAG);
  assign wb_ack_o = ackQ;
  assign wb_dat_o = {24'h000000, rdQ};

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ackQ <= 1'b0;
    else
      ackQ <= acc && !ackQ;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdQ <= 8'h00;
    else if (acc && !ackQ && !wb_we_i)
      rdQ <= rdMux;
  end

  always_comb
  begin
    if (inWin)
      rdMux = pageRdata; // R7
    else if (wb_adr_i == ADR_FLAGS)
      rdMux = flagsRd;
    else if (wb_adr_i == ADR_ENABLES)
      rdMux = {1'b0, enQ};
    else if (wb_adr_i == ADR_CTRL)
      rdMux = ctrlRd;
    else if (wb_adr_i == ADR_PRESC)
      rdMux = prescQ;
    else if (wb_adr_i == ADR_TIMING)
      rdMux = timingQ;
    else if (wb_adr_i == ADR_PAGE)
      rdMux = {5'h00, pageQ};
    else
      rdMux = 8'h00;
  end

  // The window is served by the buffer and filter storage outside this block.
  assign pageWrite = wrEn && inWin; // R7
  assign pageIndex = wb_adr_i[5:2];
  assign pageWdata = wb_dat_i[7:0];
  assign pageSel = pageQ;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  assign runRead = ctrlQ[CT_RUN] || (modeQ != MODE_STANDBY); // R26
  // Timing changes are only safe once the bit logic is really stopped.
  assign cfgOpen = !runRead; // R6

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      prescQ <= RST_PRESC;
      timingQ <= RST_TIMING;
    end
    else if (wrEn && cfgOpen)
    begin
      if (wb_adr_i == ADR_PRESC)
        prescQ <= wb_dat_i[7:0]; // R6
      else if (wb_adr_i == ADR_TIMING)
        timingQ <= {1'b0, wb_dat_i[6:0]}; // R6
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pageQ <= RST_PAGE;
    else if (wrEn && wb_adr_i == ADR_PAGE)
      pageQ <= wb_dat_i[2:0]; // R7
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      enQ <= RST_ENABLES[6:0];
    else if (wrEn && wb_adr_i == ADR_ENABLES)
      enQ <= wb_dat_i[6:0];
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      ctrlQ <= RST_CTRL[4:0];
    else if (wrEn && wb_adr_i == ADR_CTRL)
      ctrlQ <= wb_dat_i[4:0];
  end

  assign ctrlRd = {1'b0, busOffQ, errPassive, ctrlQ[4:1], runRead}; // R17 R18
  assign selfReceive = ctrlQ[CT_SELFRX]; // R19
  assign noRetry = ctrlQ[CT_NORETRY]; // R20
  assign earlyTx = enQ[EN_EARLY]; // R9
  assign coreRun = (modeQ == MODE_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing.

  assign cfg = '{prescale: prescQ.prescale, jump: prescQ.jump,
                 seg1: timingQ.seg1, seg2: timingQ.seg2};

  cbtsc_btl u_btl (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .enable(modeQ != MODE_STANDBY),
    .rxBit(canRx),
    .cfg(cfg),
    .bitOut(bitInfo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode.

  assign fastOk = ctrlQ[CT_FAST] && !busOffQ; // R21
  assign resyncDone = (modeQ == MODE_RESYNC) && bitInfo.sampleTick && bitInfo.bitValue
    && (recRunQ == RECESSIVE_RUN - 4'h1)
    && (fastOk || {1'b0, seqQ} == RESYNC_SEQS - 8'h01); // R21

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      modeQ <= MODE_STANDBY;
    else
    begin
      case (modeQ)
        MODE_STANDBY:
          if (ctrlQ[CT_RUN])
            modeQ <= ctrlQ[CT_WAKE] ? MODE_WAKEUP : MODE_RESYNC; // R22
        MODE_WAKEUP:
          if (bitInfo.bitEnd)
            modeQ <= MODE_RESYNC;
        MODE_RESYNC:
          if (!ctrlQ[CT_RUN])
            modeQ <= MODE_STANDBY;
          else if (resyncDone)
            modeQ <= MODE_ACTIVE; // R21
        MODE_ACTIVE:
          if (!ctrlQ[CT_RUN] && !core.xferBusy)
            modeQ <= MODE_STANDBY; // R26
          else if (busOffQ)
            modeQ <= MODE_RESYNC;
        default:
          modeQ <= MODE_STANDBY;
      endcase
    end
  end

  // A dominant sample restarts the run of recessive bits.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      recRunQ <= 4'h0;
      seqQ <= 7'h00;
    end
    else if (modeQ != MODE_RESYNC)
    begin
      recRunQ <= 4'h0;
      seqQ <= 7'h00;
    end
    else if (bitInfo.sampleTick)
    begin
      if (!bitInfo.bitValue)
        recRunQ <= 4'h0;
      else if (recRunQ == RECESSIVE_RUN - 4'h1)
      begin
        recRunQ <= 4'h0;
        seqQ <= seqQ + 7'h01; // R21
      end
      else
        recRunQ <= recRunQ + 4'h1;
    end
  end

  // The wake pulse covers exactly the first bit after leaving standby.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      canTxQ <= 1'b1;
    else if (modeQ == MODE_WAKEUP)
      canTxQ <= 1'b0; // R22
    else if (modeQ == MODE_ACTIVE)
      canTxQ <= core.txBit;
    else
      canTxQ <= 1'b1;
  end

  assign canTx = canTxQ;

  ////////////////////////////////////////////////////////////////////////////
  // Node state. Bus-off stays until the node resynchronises to the bus;
  // the core is expected to restart its counters at that point.

  assign errPassive = !busOffQ && (tecCount > TEC_PASSIVE || recCount > REC_PASSIVE); // R18

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      busOffQ <= 1'b0;
    else if (tecCount > TEC_BUSOFF)
      busOffQ <= 1'b1; // R17
    else if (resyncDone)
      busOffQ <= 1'b0; // R17
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      passPrevQ <= 1'b0;
      boffPrevQ <= 1'b0;
    end
    else
    begin
      passPrevQ <= errPassive;
      boffPrevQ <= busOffQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags. A set in the same cycle as a clear wins, so no event
  // is lost when software acknowledges an older one.

  assign statSet = ((modeQ == MODE_STANDBY) && !canRx)
    || ((modeQ != MODE_STANDBY) && ((errPassive && !passPrevQ) || (busOffQ && !boffPrevQ)))
    || (core.rxErr && enQ[EN_RXERR]); // R10 R15
  assign txSet = enQ[EN_EARLY] ? core.arbWon : core.txDone; // R9

  always_comb
  begin
    flagSet = '0;
    flagSet[FL_RX3:FL_RX1] = core.rxOk; // R8
    flagSet[FL_TXDONE] = txSet; // R9
    flagSet[FL_STAT] = statSet; // R10
    flagSet[FL_OVR] = core.overrun; // R11
    flagSet[FL_TXERR] = core.txErr; // R12
    flagClr = '0;
    if (wrEn && wb_adr_i == ADR_FLAGS)
      flagClr = ~wb_dat_i[7:1]; // R14
    flagClr[FL_RX3:FL_RX1] = flagClr[FL_RX3:FL_RX1] | core.rdyCleared; // R8
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      flagQ <= RST_FLAGS[7:1];
    else
      flagQ <= (flagQ & ~flagClr) | flagSet; // R14
  end

  assign pending = flagQ[FL_STAT] || flagQ[FL_OVR] || flagQ[FL_TXERR]; // R13
  assign flagsRd = {flagQ, pending};

  assign irqReq = ((|flagQ[FL_RX3:FL_RX1]) && enQ[EN_RX])
    || (flagQ[FL_TXDONE] && enQ[EN_TX])
    || (flagQ[FL_STAT] && enQ[EN_STAT])
    || (flagQ[FL_OVR] && enQ[EN_OVR])
    || (flagQ[FL_TXERR] && enQ[EN_TXERR]); // R16

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_ack_single: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc && !ackQ) |=> (ackQ ##1 !ackQ))
    else $error("ack not a single cycle");

  chk_cfg_locked: assert property (@(posedge clk_sys) disable iff (!nrst)
    (runRead ##1 runRead) |-> ($stable(timingQ) && $stable(prescQ))) // R6
    else $error("timing changed outside standby");

  chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wrEn && wb_adr_i == ADR_FLAGS && !wb_dat_i[FL_OVR] && !core.overrun)
    |=> !flagQ[FL_OVR]) // R14
    else $error("writing zero did not clear overrun");

  chk_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    core.overrun |=> flagQ[FL_OVR] && pending) // R11
    else $error("overrun event lost");

  chk_rx_ready_clr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (core.rdyCleared[0] && !core.rxOk[0]) |=> !flagQ[FL_RX1]) // R8
    else $error("ready clear left buffer 1 flag set");

  chk_tx_early: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enQ[EN_EARLY] && core.arbWon) |=> flagQ[FL_TXDONE]) // R9
    else $error("early transmit flag not set");

  chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    (enQ[EN_TX:EN_TXERR] == 4'h0 && !enQ[EN_RX]) |-> !irqReq) // R16
    else $error("interrupt raised while disabled");

  chk_run_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
    (modeQ == MODE_ACTIVE && core.xferBusy) |=> ctrlRd[CT_RUN]) // R26
    else $error("run read 0 during a transfer");

  chk_wake_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
    (modeQ == MODE_STANDBY && ctrlQ[CT_RUN] && ctrlQ[CT_WAKE])
    |=> (modeQ == MODE_WAKEUP) ##1 !canTx) // R22
    else $error("no dominant wake pulse");

  chk_no_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
    (modeQ == MODE_STANDBY && ctrlQ[CT_RUN] && !ctrlQ[CT_WAKE])
    |=> (modeQ == MODE_RESYNC) ##1 canTx) // R22
    else $error("wake pulse sent while not selected");

  chk_busoff_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tecCount > TEC_BUSOFF) |=> (busOffQ && !errPassive)) // R17 R18
    else $error("bus-off not entered");

  chk_resync_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
    (modeQ == MODE_RESYNC && !ctrlQ[CT_FAST] && ctrlQ[CT_RUN] && seqQ != 7'h7f)
    |=> (modeQ != MODE_ACTIVE)) // R21
    else $error("resync ended before 128 sequences");

endmodule
`default_nettype wire

// [testbench.sv]
`default_nettype none
module testbench;
  import cbtsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dato;
  logic ack;
  logic canRx;
  logic canTx;
  logic holdDom = 1'b0;
  logic coreRun;
  logic selfRx;
  logic noRetry;
  logic irq;
  logic early;
  logic [2:0] pgSel;
  logic pw;
  logic [3:0] pIdx;
  logic [7:0] pWd;
  logic [3:0] pwCnt = 4'h0;
  logic [11:0] pwLog = 12'h000;
  logic [8:0] tec = 9'h000;
  logic [7:0] rec = 8'h00;
  cbtsc_core_t core = cbtsc_core_t'(13'h0001);
  cbtsc_bit_t bitInfo;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  logic [23:0] rows [7] = '{24'h047b7b, 24'h0c4545, 24'h108707, 24'h140505,
    24'h20ff00, 24'h081c1c, 24'h44115a};
  logic [15:0] rsts [6] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c00, 16'h1023, 16'h1400};

  always #5 clk_sys = ~clk_sys;

  // Window writes are single-cycle strobes, so they are logged as they happen.
  always @(posedge clk_sys)
  begin
    if (pw)
    begin
      pwLog <= {pIdx, pWd};
      pwCnt <= pwCnt + 4'h1;
    end
  end

  cbtsc_top u_cbtsc_top (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dato),
    .wb_ack_o(ack), .canRx(canRx), .canTx(canTx), .core(core), .tecCount(tec),
    .recCount(rec), .pageRdata(8'h5a), .bitInfo(bitInfo), .coreRun(coreRun),
    .selfReceive(selfRx), .noRetry(noRetry), .earlyTx(early), .pageSel(pgSel),
    .pageWrite(pw), .pageIndex(pIdx), .pageWdata(pWd), .irqReq(irq));
  cbtsc_node u_cbtsc_node (.nodeTx(canTx), .holdDom(holdDom), .busLine(canRx));

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bound(input int c, input int lim);
    if (c >= lim)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdat = dato;
    cyc <= 1'b0;
    bound(n, 20);
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(rdat, {24'h0, e});
  endtask

  // Bit 0 of the core struct is the transmit level; it idles recessive so the bus stays free.
  task automatic pulse(input logic [12:0] v);
    core <= cbtsc_core_t'(v | 13'h0001);
    @(posedge clk_sys);
    core <= cbtsc_core_t'(13'h0001);
    @(posedge clk_sys);
  endtask

  task automatic wait_run(input logic v);
    n = 0;
    while (coreRun !== v && n < 3000)
    begin
      @(posedge clk_sys);
      n++;
    end
    bound(n, 3000);
  endtask

  task automatic bit_len();
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (bitInfo.bitEnd !== 1'b1 && n < 200);
    bound(n, 200);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    foreach (rsts[i])
      rd(rsts[i][15:8], rsts[i][7:0]);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    check({12'h0, pwCnt, pwLog, early, pgSel}, 32'h1111d);
    check({30'h0, selfRx, noRetry}, 32'h3);
    pulse(13'h0020);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, ADR_ENABLES, 8'h7f);
    check({31'h0, irq}, 32'h1);
    rd(ADR_FLAGS, 8'h05);
    wb(1'b1, ADR_FLAGS, 8'hfb);
    rd(ADR_FLAGS, 8'h00);
    pulse(13'h0400);
    rd(ADR_FLAGS, 8'h20);
    pulse(13'h0004);
    rd(ADR_FLAGS, 8'h00);
    pulse(13'h0200);
    pulse(13'h0080);
    pulse(13'h0040);
    pulse(13'h0100);
    rd(ADR_FLAGS, 8'h1b);
    wb(1'b1, ADR_FLAGS, 8'hef);
    rd(ADR_FLAGS, 8'h0b);
    wb(1'b1, ADR_FLAGS, 8'h00);
    holdDom <= 1'b1;
    repeat (3) @(posedge clk_sys);
    holdDom <= 1'b0;
    @(posedge clk_sys);
    rd(ADR_FLAGS, 8'h09);
    wb(1'b1, ADR_FLAGS, 8'h00);
    wb(1'b1, ADR_CTRL, 8'h1f);
    repeat (4) @(posedge clk_sys);
    check({31'h0, canTx}, 32'h0);
    wait_run(1'b1);
    bit_len();
    bit_len();
    check(n, 60);
    wb(1'b1, ADR_TIMING, 8'h33);
    rd(ADR_TIMING, 8'h07);
    core <= cbtsc_core_t'(13'h0003);
    wb(1'b1, ADR_CTRL, 8'h1c);
    rd(ADR_CTRL, 8'h1d);
    core <= cbtsc_core_t'(13'h0001);
    wait_run(1'b0);
    rd(ADR_CTRL, 8'h1c);
    wb(1'b1, ADR_CTRL, 8'h1d);
    wait_run(1'b1);
    bit_len();
    repeat (20) @(posedge clk_sys);
    holdDom <= 1'b1;
    bit_len();
    holdDom <= 1'b0;
    check(n, 52);
    rec <= 8'h80;
    rd(ADR_CTRL, 8'h3d);
    rec <= 8'h00;
    tec <= 9'h080;
    rd(ADR_CTRL, 8'h3d);
    rd(ADR_FLAGS, 8'h09);
    tec <= 9'h100;
    // Bus-off is registered, so it shows one cycle after the counter passes 255.
    @(posedge clk_sys);
    rd(ADR_CTRL, 8'h5d);
    check({31'h0, coreRun}, 32'h0);
    tec <= 9'h000;
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check({26'h0, bitInfo, canTx, coreRun, irq}, 32'h0c);
    nrst <= 1'b1;
    @(posedge clk_sys);
    foreach (rsts[i])
      rd(rsts[i][15:8], rsts[i][7:0]);
    stop_test();
  end
endmodule
`default_nettype wire
